// ==== shared/soi_pkg.sv ====
// constants, register map and types for the safety output interlock
package soi_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned TEST_PULSE_US = 300;
  localparam int unsigned PULSE_CYCLES_DFLT = (CLK_HZ / 1_000_000) * TEST_PULSE_US;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned MS_CYCLES_DFLT = CLK_HZ / MS_PER_S;
  localparam int unsigned TEST_PERIOD_MS_DFLT = 50;
  localparam logic [15:0] RESET_MIN_MS = 16'h01f4;    // 500 ms, must be exceeded
  localparam logic [15:0] RESET_MAX_MS = 16'h7530;    // 30 s, beyond is a malfunction
  localparam logic [2:0] DELAY_MIN_S = 3'h1;
  localparam logic [2:0] DELAY_MAX_S = 3'h6;
  localparam logic [15:0] ON_RESP_RST = 16'h010e;     // 270 ms

  // ---------------------------------------------------------------
  // register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_SPD_MIN = 8'h04;
  localparam logic [7:0] REG_SPD_MAX = 8'h08;
  localparam logic [7:0] REG_ON_RESP = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_MAP_IDX = 8'h14;
  localparam logic [7:0] REG_MAP_DATA = 8'h18;
  localparam logic [7:0] REG_SPEED = 8'h1c;

  // ---------------------------------------------------------------
  // control fields
  // ---------------------------------------------------------------
  localparam int unsigned CTRL_W = 14;
  localparam int unsigned CTRL_DUAL_BIT = 0;
  localparam int unsigned CTRL_MODE_LSB = 1;         // 2 bits
  localparam int unsigned CTRL_DELAY_LSB = 3;        // 3 bits, seconds
  localparam int unsigned CTRL_SPDMON_BIT = 6;
  localparam int unsigned CTRL_ENCPAT_BIT = 7;
  localparam int unsigned CTRL_AREA_LSB = 8;         // 5 bits, static area
  localparam logic [CTRL_W-1:0] CTRL_RST = 14'h0008; // auto restart, 1 s delay
  localparam logic [1:0] MODE_AUTO = 2'h0;
  localparam logic [1:0] MODE_MANUAL = 2'h1;
  localparam logic [1:0] MODE_START = 2'h2;

  // ---------------------------------------------------------------
  // speed map
  // ---------------------------------------------------------------
  localparam int unsigned MAP_ENTRIES = 32;
  localparam int unsigned SPEED_W = 16;
  localparam int unsigned AREA_W = 5;
  localparam int unsigned MAP_AREA_LSB = 16;
  localparam int unsigned MAP_VALID_BIT = 24;
  localparam logic signed [15:0] SPD_MIN_RST = 16'h8000;
  localparam logic signed [15:0] SPD_MAX_RST = 16'h7fff;

  // ---------------------------------------------------------------
  // status fields
  // ---------------------------------------------------------------
  localparam int unsigned ST_PAIR_A_BIT = 0;
  localparam int unsigned ST_PAIR_B_BIT = 1;
  localparam int unsigned ST_LOCK_BIT = 2;
  localparam int unsigned ST_TESTERR_BIT = 3;
  localparam int unsigned ST_STUCK_BIT = 4;
  localparam int unsigned ST_REQ_BIT = 5;
  localparam int unsigned ST_SPDOFF_BIT = 6;
  localparam int unsigned ST_HIT_BIT = 7;
  localparam int unsigned ST_AREA_LSB = 8;

  typedef enum logic [2:0] {
    SOI_INIT,
    SOI_RUN,
    SOI_WAIT_RESET,
    SOI_DELAY,
    SOI_LOCK
  } soi_state_e;

endpackage

// ==== hw/soi_speed_map.sv ====
// speed range table mapping the measured speed onto an area number
module soi_speed_map
  import soi_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic wr_en,
  input wire logic [AREA_W-1:0] wr_idx,
  input wire logic [31:0] wr_data,
  input wire logic signed [SPEED_W-1:0] speed,
  output logic [AREA_W-1:0] area_r,
  output logic hit_r
);

  // ---------------------------------------------------------------
  // table storage
  // ---------------------------------------------------------------
  logic signed [SPEED_W-1:0] upper_mem [MAP_ENTRIES];
  logic [AREA_W-1:0] area_mem [MAP_ENTRIES];
  logic [MAP_ENTRIES-1:0] valid_r;
  logic [AREA_W-1:0] area_nxt;
  logic hit_nxt;

  // only the valid bits need a reset, the contents are gated by them
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      valid_r <= '0;
    end else if (wr_en) begin
      valid_r[wr_idx] <= wr_data[MAP_VALID_BIT];
    end
  end

  // entry bound and area
  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      upper_mem[wr_idx] <= wr_data[SPEED_W-1:0];
      area_mem[wr_idx] <= wr_data[MAP_AREA_LSB +: AREA_W];
    end
  end

  // ---------------------------------------------------------------
  // lookup
  // ---------------------------------------------------------------
  // range to area
  // lowest valid entry whose upper bound covers the speed wins
  always_comb begin
    area_nxt = '0;
    hit_nxt = 1'b0;
    for (int i = MAP_ENTRIES - 1; i >= 0; i--) begin
      if (valid_r[i] && (speed <= upper_mem[i])) begin
        area_nxt = area_mem[i];
        hit_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      area_r <= '0;
      hit_r <= 1'b0;
    end else begin
      area_r <= area_nxt;
      hit_r <= hit_nxt;
    end
  end

endmodule

// ==== hw/soi_interlock.sv ====
// safety switching output interlock with self test, lockout and restart modes
module soi_interlock
  import soi_pkg::*;
#(
  parameter int unsigned MS_CYCLES = MS_CYCLES_DFLT,
  parameter int unsigned PULSE_CYCLES = PULSE_CYCLES_DFLT,
  parameter int unsigned TEST_PERIOD_MS = TEST_PERIOD_MS_DFLT
)(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic zone_intrusion_a,
  input wire logic zone_intrusion_b,
  input wire logic warning_zone_first,
  input wire logic warning_zone_second,
  input wire logic internal_fault,
  input wire logic init_done,
  input wire logic reset_input,
  input wire logic signed [15:0] enc_speed_1,
  input wire logic signed [15:0] enc_speed_2,
  input wire logic fb_a1,
  input wire logic fb_a2,
  input wire logic fb_b1,
  input wire logic fb_b2,
  output logic safety_output_a1,
  output logic safety_output_a2,
  output logic safety_output_b1,
  output logic safety_output_b2,
  output logic warning_output_first,
  output logic warning_output_second,
  output logic reset_request_output,
  output logic [AREA_W-1:0] area_number
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic [CTRL_W-1:0] ctrl_r;
  logic signed [SPEED_W-1:0] spd_min_r;
  logic signed [SPEED_W-1:0] spd_max_r;
  logic [15:0] on_resp_r;
  logic [AREA_W-1:0] map_idx_r;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic [31:0] rd_mux;
  logic access;
  logic [14:0] ms_div_r;
  logic ms_tick_r;
  soi_state_e state_r;
  soi_state_e state_nxt;
  logic [15:0] delay_ms_r;
  logic [15:0] hold_ms_r;
  logic reset_in_d_r;
  logic reset_valid;
  logic stuck_r;
  logic test_err_r;
  logic lock_now;
  logic [15:0] test_ms_r;
  logic [12:0] pulse_cnt_r;
  logic pulse_r;
  logic signed [SPEED_W-1:0] speed;
  logic spd_off;
  logic [1:0] zone;
  logic [1:0] pair_en;
  logic [1:0] clear_ok;
  logic [1:0] pair_on;
  logic [1:0] fb_pair;
  logic any_zone;
  logic [AREA_W-1:0] map_area;
  logic map_hit;
  logic [1:0] mode;

  assign mode = ctrl_r[CTRL_MODE_LSB +: 2];
  assign zone = {zone_intrusion_b, zone_intrusion_a};
  assign pair_en = {ctrl_r[CTRL_DUAL_BIT], 1'b1};
  assign fb_pair = {fb_b1 | fb_b2, fb_a1 | fb_a2};
  assign any_zone = |(zone & pair_en);

  // ---------------------------------------------------------------
  // helper functions
  // ---------------------------------------------------------------
  // decode for the error answer only, the read mux decodes on its own
  function automatic logic addr_mapped(input logic [7:0] a);
    case (a)
      REG_CTRL, REG_SPD_MIN, REG_SPD_MAX, REG_ON_RESP, REG_STATUS, REG_MAP_IDX, REG_MAP_DATA,
      REG_SPEED: addr_mapped = 1'b1;
      default: addr_mapped = 1'b0;
    endcase
  endfunction

  // restart delay in ms, out-of-range selections clamp into 1..6 s
  function automatic logic [15:0] delay_ms(input logic [2:0] sel);
    logic [2:0] s;
    s = sel;
    if (s < DELAY_MIN_S) begin
      s = DELAY_MIN_S;
    end else if (s > DELAY_MAX_S) begin
      s = DELAY_MAX_S;
    end
    delay_ms = 16'(s * MS_PER_S);
  endfunction

  // ---------------------------------------------------------------
  // apb slave
  // ---------------------------------------------------------------
  assign access = psel & penable & pready_r;

  // one wait-free access phase: ready rises right after setup
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
    end else begin
      pready_r <= psel & ~penable;
      if (psel & ~penable) begin
        pslverr_r <= ~addr_mapped(paddr);
        prdata_r <= pwrite ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  // read mux, unmapped and reserved bits read zero
  always_comb begin
    rd_mux = '0;
    case (paddr)
      REG_CTRL: rd_mux[CTRL_W-1:0] = ctrl_r;
      REG_SPD_MIN: rd_mux[SPEED_W-1:0] = spd_min_r;
      REG_SPD_MAX: rd_mux[SPEED_W-1:0] = spd_max_r;
      REG_ON_RESP: rd_mux[15:0] = on_resp_r;
      REG_MAP_IDX: rd_mux[AREA_W-1:0] = map_idx_r;
      REG_SPEED: rd_mux[SPEED_W-1:0] = speed;
      REG_STATUS: begin
        rd_mux[ST_PAIR_A_BIT] = safety_output_a1;
        rd_mux[ST_PAIR_B_BIT] = safety_output_b1;
        rd_mux[ST_LOCK_BIT] = (state_r == SOI_LOCK);
        rd_mux[ST_TESTERR_BIT] = test_err_r;
        rd_mux[ST_STUCK_BIT] = stuck_r;
        rd_mux[ST_REQ_BIT] = reset_request_output;
        rd_mux[ST_SPDOFF_BIT] = spd_off;
        rd_mux[ST_HIT_BIT] = map_hit;
        rd_mux[ST_AREA_LSB +: AREA_W] = area_number;
      end
      default: rd_mux = '0;
    endcase
  end

  // configuration writes land on the sampled access edge only
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ctrl_r <= CTRL_RST;
      spd_min_r <= SPD_MIN_RST;
      spd_max_r <= SPD_MAX_RST;
      on_resp_r <= ON_RESP_RST;
      map_idx_r <= '0;
    end else if (access & pwrite) begin
      case (paddr)
        REG_CTRL: ctrl_r <= pwdata[CTRL_W-1:0];
        REG_SPD_MIN: spd_min_r <= pwdata[SPEED_W-1:0];
        REG_SPD_MAX: spd_max_r <= pwdata[SPEED_W-1:0];
        REG_ON_RESP: on_resp_r <= pwdata[15:0];
        REG_MAP_IDX: map_idx_r <= pwdata[AREA_W-1:0];
        default: ;
      endcase
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

  // ---------------------------------------------------------------
  // millisecond enable
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ms_div_r <= '0;
      ms_tick_r <= 1'b0;
    end else if (ms_div_r == 15'(MS_CYCLES - 1)) begin
      ms_div_r <= '0;
      ms_tick_r <= 1'b1;
    end else begin
      ms_div_r <= ms_div_r + 15'h0001;
      ms_tick_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // speed evaluation
  // ---------------------------------------------------------------
  // larger encoder speed
  assign speed = (enc_speed_1 > enc_speed_2) ? enc_speed_1 : enc_speed_2;

  assign spd_off = ctrl_r[CTRL_SPDMON_BIT] & ~ctrl_r[CTRL_ENCPAT_BIT] &
                   ((speed < spd_min_r) | (speed > spd_max_r));

  soi_speed_map u_map (
    .core_clk(core_clk),
    .reset(reset),
    .wr_en(access & pwrite & (paddr == REG_MAP_DATA)),
    .wr_idx(map_idx_r),
    .wr_data(pwdata),
    .speed(speed),
    .area_r(map_area),
    .hit_r(map_hit)
  );

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      area_number <= '0;
    end else begin
      area_number <= ctrl_r[CTRL_ENCPAT_BIT] ? map_area : ctrl_r[CTRL_AREA_LSB +: AREA_W];
    end
  end

  // ---------------------------------------------------------------
  // reset input qualification
  // ---------------------------------------------------------------
  // hold time counts in ms and saturates just above the stuck limit
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      hold_ms_r <= '0;
      reset_in_d_r <= 1'b0;
    end else begin
      reset_in_d_r <= reset_input;
      if (!reset_input) begin
        hold_ms_r <= '0;
      end else if (ms_tick_r && (hold_ms_r <= RESET_MAX_MS)) begin
        hold_ms_r <= hold_ms_r + 16'h0001;
      end
    end
  end

  // accepted on release after more than 500 ms
  assign reset_valid = reset_in_d_r & ~reset_input & (hold_ms_r > RESET_MIN_MS) & (hold_ms_r <= RESET_MAX_MS);

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      stuck_r <= 1'b0;
    end else if (hold_ms_r > RESET_MAX_MS) begin
      stuck_r <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // periodic output test
  // ---------------------------------------------------------------
  // period timer and 300 us pulse
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      test_ms_r <= '0;
      pulse_cnt_r <= '0;
      pulse_r <= 1'b0;
    end else if (pulse_r) begin
      if (pulse_cnt_r == 13'(PULSE_CYCLES - 1)) begin
        pulse_r <= 1'b0;
        pulse_cnt_r <= '0;
      end else begin
        pulse_cnt_r <= pulse_cnt_r + 13'h0001;
      end
    end else if (ms_tick_r) begin
      if (test_ms_r == 16'(TEST_PERIOD_MS - 1)) begin
        test_ms_r <= '0;
        pulse_r <= |pair_on;
      end else begin
        test_ms_r <= test_ms_r + 16'h0001;
      end
    end
  end

  // feedback still high at pulse end means the output cannot switch off
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      test_err_r <= 1'b0;
    end else if (pulse_r && (pulse_cnt_r == 13'(PULSE_CYCLES - 1)) && |(fb_pair & pair_on & pair_en)) begin
      test_err_r <= 1'b1;
    end
  end

  // internal fault, failed test or stuck reset all lock out
  assign lock_now = internal_fault | test_err_r | stuck_r;

  // ---------------------------------------------------------------
  // zone clear timing per pair
  // ---------------------------------------------------------------
  genvar p;
  generate
    for (p = 0; p < 2; p++) begin : g_pair
      logic [15:0] clr_ms_r;
      // on response time after the zone clears
      always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
          clr_ms_r <= '0;
        end else if (zone[p]) begin
          clr_ms_r <= '0;
        end else if (ms_tick_r && (clr_ms_r < on_resp_r)) begin
          clr_ms_r <= clr_ms_r + 16'h0001;
        end
      end
      assign clear_ok[p] = ~zone[p] & (clr_ms_r >= on_resp_r);
      // off causes gate every on path
      assign pair_on[p] = pair_en[p] & (state_r == SOI_RUN) & clear_ok[p] & ~spd_off & ~lock_now;
    end
  endgenerate

  // ---------------------------------------------------------------
  // restart state machine
  // ---------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      SOI_INIT: begin
        // start interlock waits for reset from power up
        if (init_done) begin
          state_nxt = (mode == MODE_START) ? SOI_WAIT_RESET : SOI_RUN;
        end
      end
      SOI_RUN: begin
        // manual mode latches off on intrusion or error
        if ((mode == MODE_MANUAL) && (any_zone | spd_off)) begin
          state_nxt = SOI_WAIT_RESET;
        end
      end
      SOI_WAIT_RESET: begin
        // reset accepted only with a clear zone
        if (reset_valid && !any_zone && !spd_off) begin
          state_nxt = SOI_DELAY;
        end
      end
      SOI_DELAY: begin
        if (any_zone | spd_off) begin
          state_nxt = SOI_WAIT_RESET;
        end else if (ms_tick_r && (delay_ms_r == 16'h0000)) begin // one tick past zero, never short of the set delay
          state_nxt = SOI_RUN;
        end
      end
      SOI_LOCK: state_nxt = SOI_LOCK;
    endcase
    // lockout overrides everything until power cycle
    if (lock_now) begin
      state_nxt = SOI_LOCK;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_r <= SOI_INIT;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      delay_ms_r <= '0;
    end else if (state_r != SOI_DELAY) begin
      delay_ms_r <= delay_ms(ctrl_r[CTRL_DELAY_LSB +: 3]);
    end else if (ms_tick_r && (delay_ms_r != 16'h0000)) begin
      delay_ms_r <= delay_ms_r - 16'h0001;
    end
  end

  // ---------------------------------------------------------------
  // output registers
  // ---------------------------------------------------------------
  // both outputs of a pair share one source
  // lockout keeps pairs off whatever the mode
  // test pulse blanks the pair that is on
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      safety_output_a1 <= 1'b0;
      safety_output_a2 <= 1'b0;
      safety_output_b1 <= 1'b0;
      safety_output_b2 <= 1'b0;
    end else begin
      safety_output_a1 <= pair_on[0] & ~pulse_r;
      safety_output_a2 <= pair_on[0] & ~pulse_r;
      safety_output_b1 <= pair_on[1] & ~pulse_r;
      safety_output_b2 <= pair_on[1] & ~pulse_r;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      warning_output_first <= 1'b0;
      warning_output_second <= 1'b0;
    end else begin
      warning_output_first <= ~warning_zone_first & (state_r != SOI_INIT) & ~lock_now & (state_r != SOI_LOCK);
      warning_output_second <= ~warning_zone_second & (state_r != SOI_INIT) & ~lock_now & (state_r != SOI_LOCK);
    end
  end

  // request reset once ready to accept it
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      reset_request_output <= 1'b0;
    end else begin
      reset_request_output <= (state_nxt == SOI_WAIT_RESET);
    end
  end

endmodule

// ==== sim/soi_relay_model.sv ====
// relay readback model for the paired safety outputs
module soi_relay_model (
  input wire logic oa1,
  input wire logic oa2,
  input wire logic ob1,
  input wire logic ob2,
  input wire logic stuck,
  output logic fa1,
  output logic fa2,
  output logic fb1,
  output logic fb2
);
  timeunit 1ns;
  timeprecision 1ns;
  // contacts drop inside the pulse, a welded pair a stays closed
  assign fa1 = oa1 | stuck;
  assign fa2 = oa2 | stuck;
  assign fb1 = ob1;
  assign fb2 = ob2;
endmodule

// ==== sim/soi_chk_sva.sv ====
// port checker for the safety output interlock
module soi_chk
#(
  parameter int unsigned MS_CYCLES = 20,
  parameter int unsigned PULSE_CYCLES = 8
)(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic zone_intrusion_a,
  input wire logic internal_fault,
  input wire logic init_done,
  input wire logic reset_input,
  input wire logic safety_output_a1,
  input wire logic safety_output_a2,
  input wire logic safety_output_b1,
  input wire logic safety_output_b2,
  input wire logic warning_output_first,
  input wire logic reset_request_output
);
  timeunit 1ns;
  timeprecision 1ns;
  logic flt_r;
  logic [15:0] low_r;
  logic [31:0] rel_r;
  // sticky fault, low run of pair a, time since reset input release
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      flt_r <= '0;
      low_r <= '1;
      rel_r <= '1;
    end else begin
      flt_r <= flt_r | internal_fault;
      low_r <= safety_output_a1 ? '0 : low_r + 16'(low_r != '1);
      rel_r <= $fell(reset_input) ? '0 : rel_r + 32'(rel_r != '1);
    end
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);
  property p_pair_a; safety_output_a1 == safety_output_a2; endproperty
  a_pair_a: assert property (p_pair_a) else $error("pair a split");
  property p_pair_b; safety_output_b1 == safety_output_b2; endproperty
  a_pair_b: assert property (p_pair_b) else $error("pair b split");
  property p_intr; zone_intrusion_a |=> !safety_output_a1; endproperty
  a_intr: assert property (p_intr) else $error("on with intrusion");
  property p_lock; flt_r |=> !(safety_output_a1 | safety_output_b1 | warning_output_first); endproperty
  a_lock: assert property (p_lock) else $error("on in lockout");
  property p_pulse; $rose(safety_output_a1) |-> low_r >= PULSE_CYCLES - 1; endproperty
  a_pulse: assert property (p_pulse) else $error("short off pulse");
  property p_req; reset_request_output |-> !(safety_output_a1 | safety_output_b1); endproperty
  a_req: assert property (p_req) else $error("on while waiting");
  property p_init; $rose(reset_request_output) |-> init_done; endproperty
  a_init: assert property (p_init) else $error("request before init");
  property p_delay; $rose(safety_output_a1) |-> rel_r >= 1000 * MS_CYCLES - 2; endproperty
  a_delay: assert property (p_delay) else $error("restart too early");
  c_lock: cover property (flt_r);
  c_req: cover property (reset_request_output ##1 !reset_request_output);
  c_intr: cover property (zone_intrusion_a && safety_output_b1);
endmodule
bind soi_interlock soi_chk #(.MS_CYCLES(MS_CYCLES), .PULSE_CYCLES(PULSE_CYCLES)) u_chk (
  .core_clk(core_clk), .reset(reset), .zone_intrusion_a(zone_intrusion_a),
  .internal_fault(internal_fault), .init_done(init_done), .reset_input(reset_input),
  .safety_output_a1(safety_output_a1), .safety_output_a2(safety_output_a2),
  .safety_output_b1(safety_output_b1), .safety_output_b2(safety_output_b2),
  .warning_output_first(warning_output_first), .reset_request_output(reset_request_output));

// ==== sim/tb.sv ====
// self-checking bench for the safety output interlock
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import soi_pkg::*;
  localparam int MSC = 20;
  typedef struct {string nm; logic [32:0] v;} soi_exp_s;
  soi_exp_s exp_q[$];
  logic core_clk = '0, reset = '1, psel = '0, penable = '0, pwrite = '0;
  logic zone = '0, fault = '0, init = '1, rin = '0, stuck = '0, look = '0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, seed = 32'h43af9e02, prdata;
  logic signed [15:0] e1 = '0, e2 = '0;
  logic pready, pslverr, a1, a2, b1, b2, w1, w2, req, fa1, fa2, fb1, fb2;
  logic [4:0] ha = '0, hb = '0, area;
  int fail_count = 0, n_checks = 0;
  // 20 mhz clock
  always #25 core_clk = ~core_clk;
  soi_interlock #(.MS_CYCLES(MSC), .PULSE_CYCLES(8), .TEST_PERIOD_MS(5)) DUT (.core_clk(core_clk),
    .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .zone_intrusion_a(zone), .zone_intrusion_b('0),
    .warning_zone_first('0), .warning_zone_second(zone), .internal_fault(fault), .init_done(init),
    .reset_input(rin), .enc_speed_1(e1), .enc_speed_2(e2), .fb_a1(fa1), .fb_a2(fa2), .fb_b1(fb1),
    .fb_b2(fb2), .safety_output_a1(a1), .safety_output_a2(a2), .safety_output_b1(b1),
    .safety_output_b2(b2), .warning_output_first(w1), .warning_output_second(w2),
    .reset_request_output(req), .area_number(area));
  soi_relay_model u_rel (.oa1(a1), .oa2(a2), .ob1(b1), .ob2(b2), .stuck(stuck),
    .fa1(fa1), .fa2(fa2), .fb1(fb1), .fb2(fb2));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic check(input string nm, input logic [32:0] s, input logic [32:0] e);
    n_checks++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // on flags stretched so a test pulse does not read as off
  always @(posedge core_clk) begin
    ha <= a1 ? 5'h10 : ha - 5'(ha != 0);
    hb <= b1 ? 5'h10 : hb - 5'(hb != 0);
  end
  // oldest note is compared when a read answer or a look appears
  always @(posedge core_clk) begin
    if ((pready && !pwrite) || look) begin
      check(exp_q[0].nm, look ? {23'h0, area, w2, req, w1, hb != 0, ha != 0} : {pslverr, prdata}, exp_q[0].v);
      void'(exp_q.pop_front());
    end
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input string nm,
                     input logic [32:0] e);
    if (!w) exp_q.push_back('{nm, e});
    psel <= '1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= '1;
    do @(posedge core_clk); while (pready !== 1'b1);
    psel <= '0;
    penable <= '0;
    @(posedge core_clk);
  endtask
  task automatic peek(input string nm, input logic [9:0] e);
    exp_q.push_back('{nm, {23'h0, e}});
    look <= '1;
    @(posedge core_clk);
    look <= '0;
    @(posedge core_clk);
  endtask
  task automatic ms(input int n);
    repeat (n * MSC) @(posedge core_clk);
  endtask
  task automatic por();
    reset <= '1;
    repeat (12) @(posedge core_clk);
    reset <= '0;
    @(posedge core_clk);
  endtask
  // operator holds the reset switch for n ms
  task automatic press(input int n);
    rin <= '1;
    ms(n);
    rin <= '0;
    @(posedge core_clk);
  endtask
  // main sequence: auto, lockout, manual, start interlock, fault
  initial begin
    por();
    apb('0, REG_CTRL, '0, "ctrl", 33'h8);
    apb('0, REG_ON_RESP, '0, "onresp", {17'h0, ON_RESP_RST});
    apb('0, 8'h20, '0, "unmap", 33'h100000000);
    apb('1, REG_ON_RESP, 32'h2, "", '0);
    apb('1, REG_CTRL, 32'h9, "", '0);
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      e1 <= {1'b0, seed[14:0]};
      e2 <= {1'b0, seed[30:16]};
      @(posedge core_clk);
      apb('0, REG_SPEED, '0, "speed", (seed[14:0] > seed[30:16]) ? seed[14:0] : seed[30:16]);
    end
    ms(5);
    peek("auto", 10'h017);
    zone <= '1;
    ms(2);
    peek("intr", 10'h006);
    zone <= '0;
    ms(5);
    peek("back", 10'h017);
    // speed above the window drops both pairs even in auto mode
    e1 <= 16'h00c8;
    apb('1, REG_SPD_MAX, 32'h64, "", '0);
    apb('1, REG_CTRL, 32'h49, "", '0);
    ms(2);
    peek("spdoff", 10'h014);
    apb('1, REG_CTRL, 32'h9, "", '0);
    stuck <= '1;
    ms(12);
    peek("tlock", 10'h000);
    stuck <= '0;
    por();
    apb('1, REG_CTRL, 32'ha, "", '0);
    apb('1, REG_ON_RESP, 32'h2, "", '0);
    ms(5);
    zone <= '1;
    ms(2);
    zone <= '0;
    ms(5);
    peek("mhold", 10'h01c);
    press(520);
    peek("mdly", 10'h014);
    ms(900);
    peek("mdly", 10'h014);
    ms(300);
    peek("mon", 10'h015);
    init <= '0;
    por();
    apb('1, REG_CTRL, 32'hc, "", '0);
    apb('1, REG_ON_RESP, 32'h2, "", '0);
    init <= '1;
    ms(5);
    peek("sreq", 10'h01c);
    zone <= '1;
    press(520);
    peek("sbusy", 10'h00c);
    zone <= '0;
    ms(5);
    press(520);
    ms(1100);
    peek("son", 10'h015);
    fault <= '1;
    ms(2);
    peek("fault", 10'h000);
    // top table entry; a negative second encoder must not win the max
    apb('1, REG_MAP_IDX, 32'h1f, "", '0);
    apb('1, REG_MAP_DATA, 32'h0106_0064, "", '0);
    apb('1, REG_CTRL, 32'h80, "", '0);
    e1 <= 16'h0032;
    e2 <= 16'hffec;
    ms(1);
    peek("map", 10'h0c0);
    e2 <= 16'h00c8;
    ms(1);
    peek("nomap", 10'h000);
    stop_test();
  end
  // watchdog
  initial begin
    repeat (100000) @(posedge core_clk);
    fail_count++;
    stop_test();
  end
endmodule
